// *** include/inv_ctrl_defs.vh ***
// Constants for the inverter supervisory control block
`ifndef INV_CTRL_DEFS_VH
`define INV_CTRL_DEFS_VH
`define STEPS_MIN          8'h22
`define STEPS_MAX          8'h34
`define SPACING_MIN        8'h04
`define SPACING_MAX        8'hFF
`define SPACING_DEFAULT    8'h3B
`define MODE_OFF           2'h0
`define MODE_SEARCH_SELECT          2'h1
`define MODE_ON            2'h2
`define CURSOR_LAST        3'h2
`define REG_MODE           4'h0
`define REG_THRESH         4'h1
`define REG_SPACING        4'h2
`define REG_CUTOUT         4'h3
`define REG_DELAY          4'h4
`define REG_CUTIN          4'h5
`define REG_GEN            4'h6
`define REG_STATUS         4'h7
`define REG_IRQ            4'h8
`define REG_MASK           4'h9
`define CLK_HZ             50000000
`define BLINK_MS           500
`define BLINK_CYCLES       ((`CLK_HZ / 1000) * `BLINK_MS)
`define MS_CYCLES          (`CLK_HZ / 1000)
`define IRQ_LOW_BATT       0
`define IRQ_LOAD_FOUND     1
`define IRQ_GEN_REQ        2
`define IRQ_RECOVER        3
`endif

// *** rtl/inverter_search_lowbatt_control.v ***
// Inverter supervisory control: search mode, batt_shutoff_level, indicators
//
// Operation
// - Stepped sine, 34 to 52 steps
// - Search emits single-cycle pulses with gap
// - Detected load gives continuous full output
// - Gap counted in cycles, 4..255, default 59
// - Load below threshold keeps search
// - Search or on setting selects mode
// - Menu press moves cursor right
// - Invert lamp blinks searching, steady full
// - Shut off after continuous low for delay
// - Generator start request after selected time
// - AC input present resumes as charger
// - Off then search or on clears shutoff
// - Recover when battery reaches cut-in level
// - Fault lamp lit while shut off
`include "inv_ctrl_defs.vh"
module inverter_search_lowbatt_control #(
  parameter  W            = 12,
  parameter  BLINK_CYCLES = `BLINK_CYCLES,
  parameter  MS_CYCLES    = `MS_CYCLES
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [3:0]   addr,
  input  wire [15:0]  wdata,
  input  wire         wr_en,
  input  wire         rd_en,
  output reg  [15:0]  rdata,
  input  wire         menu_button,
  input  wire         ac_cycle_tick,
  input  wire         load_sense_valid,
  input  wire [W-1:0] load_power,
  input  wire [W-1:0] batt_level,
  input  wire         utility_ac_input,
  input  wire         generator_ac_input,
  output reg          full_output,
  output reg          pulse_output,
  output reg          charger_mode,
  output reg          gen_start_req,
  output reg          invert_led,
  output reg          fault_led,
  output reg          low_batt_shutoff,
  output reg  [7:0]   steps,
  output reg  [2:0]   menu_cursor,
  output reg          irq
);
  localparam [3:0] A_MODE   = `REG_MODE;
  localparam [3:0] A_THRESH = `REG_THRESH;
  localparam [3:0] A_SPACE  = `REG_SPACING;
  localparam [3:0] A_CUTOUT = `REG_CUTOUT;
  localparam [3:0] A_DELAY  = `REG_DELAY;
  localparam [3:0] A_CUTIN  = `REG_CUTIN;
  localparam [3:0] A_GEN    = `REG_GEN;
  localparam [3:0] A_STATUS = `REG_STATUS;
  localparam [3:0] A_IRQ    = `REG_IRQ;
  localparam [3:0] A_MASK   = `REG_MASK;
  localparam [4:0] S_OFF    = 5'h01;
  localparam [4:0] S_SEARCH = 5'h02;
  localparam [4:0] S_FULL   = 5'h04;
  localparam [4:0] S_SHUT   = 5'h08;
  localparam [4:0] S_CHG    = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [1:0] s_btn;
  reg [1:0] s_ut;
  reg [1:0] s_gen;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_btn <= 2'h0;
      s_ut  <= 2'h0;
      s_gen <= 2'h0;
    end else begin
      s_btn <= {s_btn[0], menu_button};
      s_ut  <= {s_ut[0], utility_ac_input};
      s_gen <= {s_gen[0], generator_ac_input};
    end
  end
  reg btn_d;
  wire btn_press = s_btn[1] & ~btn_d;
  wire ac_present = s_ut[1] | s_gen[1];

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers
  reg [1:0]   mode_sel;
  reg [W-1:0] search_thresh;
  reg [W-1:0] batt_shutoff_level;
  reg [W-1:0] batt_recover_level;
  reg [7:0]   spacing;
  reg [15:0]  shutoff_hold_time, gen_hold_time;
  reg         gen_auto_en;
  reg [3:0]   irq_status, irq_mask;
  reg [3:0]   ev;
  reg [4:0]   state;
  reg         saw_off;

  function [7:0] clamp_spacing(input [7:0] v);
    clamp_spacing = (v < `SPACING_MIN) ? `SPACING_MIN : v;
  endfunction

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_sel           <= `MODE_OFF;
      search_thresh      <= {W{1'b0}};
      spacing            <= `SPACING_DEFAULT;
      batt_shutoff_level <= {W{1'b0}};
      batt_recover_level <= {W{1'b1}};
      shutoff_hold_time  <= 16'h0000;
      gen_hold_time      <= 16'h0000;
      gen_auto_en        <= 1'b0;
      irq_mask           <= 4'h0;
      menu_cursor        <= 3'h0;
      btn_d              <= 1'b0;
    end else begin
      btn_d <= s_btn[1];
      if (btn_press) begin
        menu_cursor <= (menu_cursor == `CURSOR_LAST) ? 3'h0 : menu_cursor + 3'h1;
        if (menu_cursor == 3'h0)
          mode_sel <= `MODE_OFF;
        else if (menu_cursor == 3'h1)
          mode_sel <= `MODE_SEARCH_SELECT;
        else
          mode_sel <= `MODE_ON;
      end
      if (wr_en) begin
        case (addr)
          A_MODE:   mode_sel <= (wdata[1:0] == 2'h3) ? `MODE_ON : wdata[1:0];
          A_THRESH: search_thresh <= wdata[W-1:0];
          A_SPACE:  spacing <= clamp_spacing(wdata[7:0]);
          A_CUTOUT: batt_shutoff_level <= wdata[W-1:0];
          A_DELAY:  shutoff_hold_time <= wdata;
          A_CUTIN:  batt_recover_level <= wdata[W-1:0];
          A_GEN: begin
            gen_hold_time <= {1'b0, wdata[14:0]};
            gen_auto_en   <= wdata[15];
          end
          A_MASK:   irq_mask <= wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and low battery timers
  reg [15:0] ms_div;
  wire ms_tick = (ms_div == MS_CYCLES[15:0] - 16'h0001);
  wire batt_low = batt_level < batt_shutoff_level;
  reg [15:0] low_ms;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ms_div <= 16'h0000;
      low_ms <= 16'h0000;
    end else begin
      // Divider restarts so a low spell is timed from its start
      if (!batt_low) begin
        ms_div <= 16'h0000;
        low_ms <= 16'h0000;
      end else begin
        ms_div <= ms_tick ? 16'h0000 : ms_div + 16'h0001;
        if (ms_tick && low_ms != 16'hFFFF)
          low_ms <= low_ms + 16'h0001;
      end
    end
  end
  wire run = (state == S_SEARCH) || (state == S_FULL);
  wire cut_now = run && batt_low && (low_ms >= shutoff_hold_time);
  wire gen_now = gen_auto_en && batt_low && (low_ms >= gen_hold_time);

  ////////////////////////////////////////////////////////////////////////////
  // Search pulse spacing in AC cycles
  reg [7:0] gap_cnt;
  reg       in_pulse;
  wire load_found = load_sense_valid && (load_power >= search_thresh);

  ////////////////////////////////////////////////////////////////////////////
  // Main state machine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state    <= S_OFF;
      saw_off  <= 1'b0;
      gap_cnt  <= 8'h00;
      in_pulse <= 1'b0;
      ev       <= 4'h0;
    end else begin
      ev <= 4'h0;
      case (state)
        S_OFF: begin
          // First pulse waits for the next cycle start
          if (mode_sel == `MODE_SEARCH_SELECT) begin
            state    <= S_SEARCH;
            in_pulse <= 1'b0;
            gap_cnt  <= 8'h01;
          end else if (mode_sel == `MODE_ON)
            state <= S_FULL;
        end
        S_SEARCH: begin
          if (cut_now) begin
            state <= S_SHUT;
            ev[`IRQ_LOW_BATT] <= 1'b1;
          end else if (mode_sel == `MODE_OFF)
            state <= S_OFF;
          else if (mode_sel == `MODE_ON)
            state <= S_FULL;
          else if (in_pulse && load_found) begin
            state <= S_FULL;
            ev[`IRQ_LOAD_FOUND] <= 1'b1;
          end else if (ac_cycle_tick) begin
            if (in_pulse) begin
              in_pulse <= 1'b0;
              gap_cnt  <= spacing;
            end else if (gap_cnt <= 8'h01)
              in_pulse <= 1'b1;
            else
              gap_cnt <= gap_cnt - 8'h01;
          end
        end
        S_FULL: begin
          if (cut_now) begin
            state <= S_SHUT;
            ev[`IRQ_LOW_BATT] <= 1'b1;
          end else if (mode_sel == `MODE_OFF)
            state <= S_OFF;
          else if (mode_sel == `MODE_SEARCH_SELECT && load_sense_valid && !load_found) begin
            state    <= S_SEARCH;
            in_pulse <= 1'b0;
            gap_cnt  <= spacing;
          end
        end
        S_SHUT: begin
          if (mode_sel == `MODE_OFF)
            saw_off <= 1'b1;
          if (ac_present) begin
            state   <= S_CHG;
            saw_off <= 1'b0;
            ev[`IRQ_RECOVER] <= 1'b1;
          end else if (batt_level >= batt_recover_level) begin
            state   <= S_OFF;
            saw_off <= 1'b0;
            ev[`IRQ_RECOVER] <= 1'b1;
          end else if (saw_off && mode_sel != `MODE_OFF) begin
            state   <= S_OFF;
            saw_off <= 1'b0;
            ev[`IRQ_RECOVER] <= 1'b1;
          end
        end
        S_CHG: begin
          if (!ac_present)
            state <= S_OFF;
        end
        default: state <= S_OFF;
      endcase
      if (gen_now && !gen_start_req)
        ev[`IRQ_GEN_REQ] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, a new event wins
  wire [3:0] irq_clear = (wr_en && addr == A_IRQ) ? wdata[3:0] : 4'h0;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_status <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | ev;
      irq        <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow blink for the invert lamp
  reg [25:0] blink_cnt;
  reg        blink;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blink_cnt <= 26'h000_0000;
      blink     <= 1'b0;
    end else if (blink_cnt == BLINK_CYCLES[25:0] - 26'h000_0001) begin
      blink_cnt <= 26'h000_0000;
      blink     <= ~blink;
    end else
      blink_cnt <= blink_cnt + 26'h000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators and outputs
  wire [7:0] steps_calc;
  step_count_calc #(.W(W)) u_steps (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .batt_level (batt_level),
    .out_power  (load_power),
    .steps      (steps_calc)
  );
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_output      <= 1'b0;
      pulse_output     <= 1'b0;
      charger_mode     <= 1'b0;
      gen_start_req    <= 1'b0;
      invert_led       <= 1'b0;
      fault_led        <= 1'b0;
      low_batt_shutoff <= 1'b0;
      steps            <= `STEPS_MIN;
    end else begin
      full_output      <= (state == S_FULL);
      pulse_output     <= (state == S_SEARCH) && in_pulse;
      charger_mode     <= (state == S_CHG);
      gen_start_req    <= gen_now;
      invert_led       <= (state == S_FULL) | ((state == S_SEARCH) & blink);
      fault_led        <= (state == S_SHUT);
      low_batt_shutoff <= (state == S_SHUT);
      steps            <= steps_calc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data stand one cycle after the strobe
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd_en) begin
      case (addr)
        A_MODE:   rdata <= {14'h0000, mode_sel};
        A_THRESH: rdata <= {{(16-W){1'b0}}, search_thresh};
        A_SPACE:  rdata <= {8'h00, spacing};
        A_CUTOUT: rdata <= {{(16-W){1'b0}}, batt_shutoff_level};
        A_DELAY:  rdata <= shutoff_hold_time;
        A_CUTIN:  rdata <= {{(16-W){1'b0}}, batt_recover_level};
        A_GEN:    rdata <= {gen_auto_en, gen_hold_time[14:0]};
        A_STATUS: rdata <= {3'h0, steps, state};
        A_IRQ:    rdata <= {12'h000, irq_status};
        A_MASK:   rdata <= {12'h000, irq_mask};
        default:  rdata <= 16'h0000;
      endcase
    end else
      rdata <= 16'h0000;
  end
endmodule // inverter_search_lowbatt_control

// *** rtl/step_count_calc.v ***
// Step count per AC cycle from battery level and output power
`include "inv_ctrl_defs.vh"
module step_count_calc #(
  parameter W = 12
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [W-1:0] batt_level,
  input  wire [W-1:0] out_power,
  output reg  [7:0]   steps
);
  wire [W-1:0] batt_deficit = ~batt_level;
  wire [W:0]   load_sum     = {1'b0, batt_deficit} + {1'b0, out_power};
  wire [4:0]   extra        = load_sum[W:W-4];
  wire [7:0]   raw          = `STEPS_MIN + {3'h0, extra};
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      steps <= `STEPS_MIN;
    else if (raw > `STEPS_MAX)
      steps <= `STEPS_MAX;
    else
      steps <= raw;
  end
endmodule // step_count_calc

// *** sim/ac_load_model.sv ***
// AC line tick and load sensing model
module ac_load_model #(
  parameter int TICK = 8
) (
  input  logic        ref_clk,
  input  logic        rst,
  input  logic        pulse_output,
  input  logic        full_output,
  input  logic [11:0] load_w,
  output logic        ac_cycle_tick,
  output logic        load_sense_valid,
  output logic [11:0] load_power
);
  timeunit 1ns;
  timeprecision 1ns;
  int  cnt;
  wire sense = (cnt == TICK / 2) && (pulse_output || full_output);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      ac_cycle_tick <= 1'b0;
      load_sense_valid <= 1'b0;
      load_power <= 12'h000;
    end else begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      ac_cycle_tick <= (cnt == TICK - 1);
      // Load draws only while energised
      load_sense_valid <= sense;
      load_power <= sense ? load_w : ~load_power;
    end
  end
endmodule // ac_load_model

// *** sim/inv_ctrl_checker.sv ***
// Port checker for the inverter supervisory control
module inv_ctrl_checker (
  input logic       ref_clk,
  input logic       rst,
  input logic       full_output,
  input logic       pulse_output,
  input logic       charger_mode,
  input logic       invert_led,
  input logic       fault_led,
  input logic       low_batt_shutoff,
  input logic [7:0] steps,
  input logic [2:0] menu_cursor
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  step_range_a: assert property (steps >= 8'h22 && steps <= 8'h34)
    else $error("step count out of range");
  one_drive_a: assert property (!(full_output && pulse_output))
    else $error("pulse and full output together");
  pulse_gap_a: assert property ($fell(pulse_output) && !full_output |-> !pulse_output [*4])
    else $error("search gap too short");
  steady_lamp_a: assert property (full_output [*2] |-> invert_led)
    else $error("invert lamp not steady at full output");
  shut_quiet_a: assert property (low_batt_shutoff |-> !full_output && !pulse_output)
    else $error("output while shut off");
  fault_lamp_a: assert property (fault_led == low_batt_shutoff)
    else $error("fault lamp differs from shutoff");
  charger_quiet_a: assert property (charger_mode |-> !full_output && !pulse_output)
    else $error("inverting while charging");
  cursor_range_a: assert property (menu_cursor <= 3'h2)
    else $error("cursor beyond last place");
  cursor_step_a: assert property ($changed(menu_cursor) |->
    menu_cursor == (($past(menu_cursor) == 3'h2) ? 3'h0 : $past(menu_cursor) + 3'h1))
    else $error("cursor did not step right");
endmodule // inv_ctrl_checker

bind inverter_search_lowbatt_control inv_ctrl_checker u_chk (.ref_clk(ref_clk), .rst(rst),
  .full_output(full_output), .pulse_output(pulse_output), .charger_mode(charger_mode),
  .invert_led(invert_led), .fault_led(fault_led), .low_batt_shutoff(low_batt_shutoff),
  .steps(steps), .menu_cursor(menu_cursor));

// *** sim/inverter_search_lowbatt_control_tb.sv ***
// Self-checking bench for the inverter supervisory control
module inverter_search_lowbatt_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, rst = 1, wr_en = 0, rd_en = 0, menu_button = 0, rd_seen = 0, p;
  logic        utility_ac_input = 0, generator_ac_input = 0, ac_cycle_tick, load_sense_valid;
  logic        full_output, pulse_output, charger_mode, gen_start_req, invert_led, fault_led;
  logic        low_batt_shutoff, irq;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [11:0] batt_level = 12'h800, load_w = 12'h000, load_power;
  logic [7:0]  steps;
  logic [2:0]  menu_cursor;
  logic [15:0] exp_q[$];
  int          n_mismatch = 0, checks = 0, k, t;
  always #10 ref_clk = ~ref_clk;
  inverter_search_lowbatt_control #(.BLINK_CYCLES(8), .MS_CYCLES(4)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .menu_button(menu_button),
    .ac_cycle_tick(ac_cycle_tick), .load_sense_valid(load_sense_valid), .load_power(load_power),
    .batt_level(batt_level), .utility_ac_input(utility_ac_input), .generator_ac_input(generator_ac_input),
    .full_output(full_output), .pulse_output(pulse_output), .charger_mode(charger_mode),
    .gen_start_req(gen_start_req), .invert_led(invert_led), .fault_led(fault_led),
    .low_batt_shutoff(low_batt_shutoff), .steps(steps), .menu_cursor(menu_cursor), .irq(irq));
  ac_load_model u_load (.ref_clk(ref_clk), .rst(rst), .pulse_output(pulse_output), .full_output(full_output),
    .load_w(load_w), .ac_cycle_tick(ac_cycle_tick), .load_sense_valid(load_sense_valid), .load_power(load_power));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp16(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(logic got, logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1;
    @(posedge ref_clk);
    wr_en <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd_en <= 0;
  endtask
  // Read data are compared in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0) cmp16(rdata, exp_q.pop_front());
    rd_seen <= rd_en;
  end
  function automatic logic sig(int s);
    case (s)
      0: return full_output;
      1: return pulse_output;
      2: return low_batt_shutoff;
      default: return charger_mode;
    endcase
  endfunction
  task automatic wait_for(int s, logic v, int n);
    for (k = 0; sig(s) !== v && k < n; k++) cyc(1);
    if (sig(s) !== v) begin
      n_mismatch++;
      $display("ERROR %0t wait ran out", $time);
      results();
    end
  endtask
  task automatic press();
    @(posedge ref_clk);
    menu_button <= 1;
    cyc(4);
    @(posedge ref_clk);
    menu_button <= 0;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    k = $urandom(29);
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    rd(4'h2, 16'h003B);
    rd(4'h5, 16'h0FFF);
    rd(4'hF, 16'h0000);
    wr(4'h2, 16'h0002);
    rd(4'h2, 16'h0004);
    wr(4'h2, 16'h00FF);
    rd(4'h2, 16'h00FF);
    wr(4'h2, 16'h0004);
    wr(4'h1, 16'h0064);
    wr(4'h9, 16'h000F);
    for (int i = 1; i <= 3; i++) begin
      press();
      cmp1(menu_cursor === 3'(i % 3), 1);
    end
    rd(4'h0, 16'h0002);
    load_w <= 12'($urandom_range(99, 1));
    wr(4'h0, 16'h0001);
    wait_for(1, 1, 80);
    k = 0;
    t = 0;
    p = invert_led;
    repeat (80) begin
      cyc(1);
      k += pulse_output;
      t += (invert_led !== p);
      p = invert_led;
    end
    cmp16(16'(k), 16'h0010);
    cmp1(t > 2, 1);
    cmp1(full_output, 0);
    cmp1(steps >= 8'h22 && steps <= 8'h34, 1);
    load_w <= 12'h064;
    wait_for(0, 1, 100);
    rd(4'h8, 16'h0002);
    cyc(1);
    cmp1(irq, 1);
    wr(4'h8, 16'h0002);
    cyc(40);
    cmp1(irq, 0);
    cmp1(full_output, 1);
    wr(4'h9, 16'h0000);
    wr(4'h3, 16'h0400);
    wr(4'h4, 16'h0005);
    wr(4'h6, 16'h8002);
    @(posedge ref_clk) batt_level <= 12'h100;
    cyc(12);
    @(posedge ref_clk) batt_level <= 12'h800;
    cyc(2);
    @(posedge ref_clk) batt_level <= 12'h100;
    cyc(17);
    cmp1(low_batt_shutoff, 0);
    wait_for(2, 1, 10);
    cmp1(fault_led, 1);
    cmp1(gen_start_req, 1);
    rd(4'h8, 16'h0005);
    cmp1(irq, 0);
    wr(4'h9, 16'h0001);
    cyc(2);
    cmp1(irq, 1);
    wr(4'h8, 16'h000F);
    cyc(2);
    cmp1(irq, 0);
    wr(4'h5, 16'h0900);
    @(posedge ref_clk) batt_level <= 12'h500;
    cyc(8);
    cmp1(low_batt_shutoff, 1);
    @(posedge ref_clk) batt_level <= 12'h900;
    wait_for(2, 0, 10);
    cmp1(fault_led, 0);
    @(posedge ref_clk) batt_level <= 12'h100;
    wait_for(2, 1, 40);
    @(posedge ref_clk) batt_level <= 12'h500;
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0002);
    wait_for(2, 0, 6);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) batt_level <= 12'h100;
      wait_for(2, 1, 40);
      @(posedge ref_clk) utility_ac_input <= (i == 0);
      generator_ac_input <= (i == 1);
      wait_for(3, 1, 10);
      cmp1(low_batt_shutoff, 0);
      @(posedge ref_clk) utility_ac_input <= 0;
      generator_ac_input <= 0;
      batt_level <= 12'h500;
      wait_for(3, 0, 10);
    end
    results();
  end
endmodule // inverter_search_lowbatt_control_tb
